/* File: dpc_pkg.sv */
package dpc_pkg;

	localparam int CLK_NS = 10;

	// Longest stay in light sleep, with headroom for the crossing and handshake
	localparam int            NAP_MAX_NS    = 10000;
	localparam int            NAP_MARGIN    = 64;
	localparam logic [9:0]    NAP_LIMIT_CYC = 10'(NAP_MAX_NS / CLK_NS - NAP_MARGIN);

	// Channel clock cycle counts
	localparam logic [7:0]    FRM_MIN       = 8'h07;
	localparam logic [7:0]    FRM_MAX       = 8'h0A;
	localparam logic [7:0]    RD_TO_CC      = 8'h0C;
	localparam logic [7:0]    CC_TO_RD      = 8'h08;
	localparam logic [7:0]    CLK_PRE       = 8'h02;
	localparam logic [7:0]    CLK_POST      = 8'h64;
	localparam logic [7:0]    ENTRY_QUIET   = 8'h04;
	localparam logic [7:0]    TEMP_CALIBRATE_CMD_GAP      = 8'h96;
	localparam logic [7:0]    TEMP_CALIBRATE_CMD_TO_Q     = 8'h02;
	localparam logic [7:0]    TEMP_CALIBRATE_CMD_QUIET    = 8'h8C;
	localparam logic [7:0]    EXIT_SETUP    = 8'h01;
	localparam logic [7:0]    EXIT_HOLD     = 8'h05;

	// Serial clock: half periods in system clocks, rounded up, never below one
	localparam int            SCK_REG_NS    = 1000;
	localparam int            SCK_PWR_NS    = 10;
	localparam int            SCK_REG_H     = (SCK_REG_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
	localparam int            SCK_PWR_H     = (SCK_PWR_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
	localparam logic [6:0]    SCK_REG_HALF  = 7'((SCK_REG_H < 1) ? 1 : SCK_REG_H);
	localparam logic [6:0]    SCK_PWR_HALF  = 7'((SCK_PWR_H < 1) ? 1 : SCK_PWR_H);

	localparam int            DEV_W         = 5;
	localparam int            BANK_W        = 5;
	localparam logic [7:0]    NBANK         = 8'h20;

	// Bus patterns driven with each packet strobe
	localparam logic [2:0]    ROW_ACT       = 3'h1;
	localparam logic [2:0]    ROW_TEMP_CALIBRATE_CMD      = 3'h2;
	localparam logic [2:0]    ROW_REF       = 3'h4;
	localparam logic [4:0]    COL_ACT       = 5'h01;
	localparam logic [4:0]    COL_RD        = 5'h02;
	localparam logic [4:0]    COL_CC        = 5'h04;

	typedef enum logic [2:0] {
		OP_READ = 3'b000,
		OP_CCAL = 3'b001,
		OP_TEMP_CALIBRATE_CMD = 3'b010,
		OP_ATTENTION_STATE = 3'b011,
		OP_NAP  = 3'b100,
		OP_PDN  = 3'b101,
		OP_EXIT = 3'b110
	} dpc_op_e;

	typedef enum logic [2:0] {
		L_IDLE    = 3'b000,
		L_FRAME   = 3'b001,
		L_ENTER   = 3'b010,
		L_SLEEP   = 3'b011,
		L_EXIT_W  = 3'b100,
		L_EXIT_Q  = 3'b101,
		L_REFRESH = 3'b110
	} dpc_lst_e;

endpackage : dpc_pkg

/* File: dpc_link_if.sv */
`timescale 1ns/1ns
interface dpc_link_if;
	import dpc_pkg::*;
	logic                valid;
	dpc_op_e             op;
	logic [DEV_W-1:0]    dev;
	logic                take;
	modport cdc  (output valid, output op, output dev, input take);
	modport core (input valid, input op, input dev, output take);
endinterface : dpc_link_if

/* File: dpc_cdc.sv */
`timescale 1ns/1ns
module dpc_cdc (
	input  wire logic                       clk,
	input  wire logic                       srst,
	input  wire logic                       in_valid,
	input  wire dpc_pkg::dpc_op_e           in_op,
	input  wire logic [dpc_pkg::DEV_W-1:0]  in_dev,
	output logic                            in_ready,
	input  wire logic                       link_clk,
	input  wire logic                       link_rst,
	dpc_link_if.cdc                         lk
);
	import dpc_pkg::*;

	typedef struct packed {
		logic                busy;
		dpc_op_e             op;
		logic [DEV_W-1:0]    dev;
		logic                req;
		logic                ack_s1;
		logic                ack_s2;
	} dpc_csys_s;

	typedef struct packed {
		logic                req_s1;
		logic                req_s2;
		logic                ack;
	} dpc_clnk_s;

	dpc_csys_s    s_reg;
	dpc_csys_s    s_next;
	dpc_clnk_s    l_reg;
	dpc_clnk_s    l_next;

	// Word is held in system flops until acknowledged, so the link side reads it stable
	always_comb begin
		s_next        = s_reg;
		s_next.ack_s1 = l_reg.ack;
		s_next.ack_s2 = s_reg.ack_s1;
		if (!s_reg.busy && in_valid) begin
			s_next.busy = 1'b1;
			s_next.op   = in_op;
			s_next.dev  = in_dev;
			s_next.req  = ~s_reg.req;
		end else if (s_reg.busy && (s_reg.ack_s2 == s_reg.req)) begin
			s_next.busy = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	always_comb begin
		l_next        = l_reg;
		l_next.req_s1 = s_reg.req;
		l_next.req_s2 = l_reg.req_s1;
		if (lk.take) begin
			l_next.ack = ~l_reg.ack;
		end
	end

	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			l_reg <= '0;
		end else begin
			l_reg <= l_next;
		end
	end

	assign in_ready = !s_reg.busy;
	assign lk.valid = l_reg.req_s2 != l_reg.ack;
	assign lk.op    = s_reg.op;
	assign lk.dev   = s_reg.dev;

endmodule : dpc_cdc

/* File: dpc_sck_gen.sv */
`timescale 1ns/1ns
module dpc_sck_gen (
	input  wire logic    clk,
	input  wire logic    srst,
	input  wire logic    fast,
	output logic         sck
);
	import dpc_pkg::*;

	typedef struct packed {
		logic [6:0]    cnt;
		logic          sck;
	} dpc_sck_s;

	dpc_sck_s      q_reg;
	dpc_sck_s      q_next;
	logic [6:0]    half;

	// Rate follows the power-transition flag; a change takes effect within the half period already under way
	always_comb begin
		q_next = q_reg;
		half   = fast ? SCK_PWR_HALF : SCK_REG_HALF; // see R11
		if (q_reg.cnt >= half - 7'h01) begin
			q_next.cnt = 7'h00;
			q_next.sck = ~q_reg.sck;
		end else begin
			q_next.cnt = q_reg.cnt + 7'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	assign sck = q_reg.sck;

	a_sck_half_len: assert property (@(posedge clk) disable iff (srst)
		$changed(q_reg.sck) |-> q_reg.cnt == 7'h00) // see R11
		else $error("serial clock toggled off its half-period count");

endmodule : dpc_sck_gen

/* File: dpc_host.sv */
`timescale 1ns/1ns
// Functional notes
// R01: Light sleep never lasts past 10 us; an automatic exit is issued first.
// R02: Column framing packet follows the row framing packet by 7 to 10 cycles.
// R03: At least 12 channel cycles from read data to a current calibration packet.
// R04: At least 8 cycles from calibration packet to read of that device.
// R05: Channel clock runs at least 2 cycles before any sleep exit begins.
// R06: Channel clock keeps running at least 100 cycles after sleep entry.
// R07: Row and column wires stay quiet 4 cycles during sleep entry.
// R08: Temperature calibrate commands are spaced by at least 150 cycles.
// R09: Temperature quiet window starts exactly 2 cycles after the command.
// R10: No read data during the 140-cycle temperature quiet window.
// R11: Serial clock period 1000 ns for registers, 10 ns for power steps; the code gives 20 ns for power steps.
// R12: Row 2..0 and column 4..0 quiet from 1 before to 5 after exit.
// R13: After exit with self-refresh, every bank is refreshed once in a burst.
// R14: Current calibration goes to one device only; the device field then steps.
module dpc_host #(
	parameter int FRM_DLY = 7,
	parameter int NDEV    = 4
) (
	input  wire logic                       clk,
	input  wire logic                       srst,
	input  wire logic                       chan_clk,
	input  wire logic                       cmd_valid,
	input  wire dpc_pkg::dpc_op_e           cmd_op,
	input  wire logic [dpc_pkg::DEV_W-1:0]  cmd_dev,
	output logic                            cmd_ready,
	input  wire logic                       self_refresh_en,
	output logic [2:0]                      row_bits,
	output logic [4:0]                      col_bits,
	output logic                            row_frame,
	output logic                            col_frame,
	output logic                            read_strobe,
	output logic                            cc_strobe,
	output logic                            temp_calibrate_cmd_strobe,
	output logic [dpc_pkg::DEV_W-1:0]       dev_o,
	output logic                            sleep_entry,
	output logic                            cfm_en,
	output logic                            exit_strobe,
	output logic                            ref_valid,
	output logic [dpc_pkg::BANK_W-1:0]      ref_bank,
	output logic                            sck
);
	import dpc_pkg::*;

	typedef struct packed {
		dpc_lst_e            st;
		logic [7:0]          cnt;
		logic [7:0]          since_rd;
		logic [7:0]          since_cc;
		logic [7:0]          since_temp_calibrate_cmd;
		logic [DEV_W-1:0]    cc_last;
		logic [DEV_W-1:0]    cc_dev;
		logic [DEV_W-1:0]    dev_o;
		logic                deep_sleep_state;
		logic                sr_s1;
		logic                sr_s2;
		logic                nap_lvl;
		logic                pwr_lvl;
		logic                cfm_en;
		logic [2:0]          row_bits;
		logic [4:0]          col_bits;
		logic                row_frame;
		logic                col_frame;
		logic                read_stb;
		logic                cc_stb;
		logic                temp_calibrate_cmd_stb;
		logic                sleep_entry;
		logic                exit_stb;
		logic                ref_valid;
		logic [BANK_W-1:0]   ref_bank;
	} dpc_link_s;

	typedef struct packed {
		logic          nap_s1;
		logic          nap_s2;
		logic          pwr_s1;
		logic          pwr_s2;
		logic [9:0]    nap_cnt;
		logic          auto_sent;
	} dpc_sys_s;

	localparam logic [7:0]       FRM_CYC  = 8'(FRM_DLY);
	localparam logic [DEV_W-1:0] DEV_LAST = DEV_W'(NDEV - 1);
	localparam logic [7:0]       Q_END    = TEMP_CALIBRATE_CMD_TO_Q + TEMP_CALIBRATE_CMD_QUIET;

	dpc_link_s           l_reg;
	dpc_link_s           l_next;
	dpc_sys_s            s_reg;
	dpc_sys_s            s_next;
	logic [1:0]          lrst_reg;
	logic                link_rst;
	logic                auto_exit;
	logic                cdc_valid;
	logic                cdc_ready;
	dpc_op_e             cdc_op;
	logic [DEV_W-1:0]    cdc_dev;
	logic                rd_ok;
	logic                quiet;

	dpc_link_if lk ();

	// Reset reaches the channel domain through two flops
	always_ff @(posedge chan_clk) begin
		lrst_reg <= {lrst_reg[0], srst};
	end
	assign link_rst = lrst_reg[1];

	// System side: watch the sleep level and force an exit before the limit
	always_comb begin
		s_next        = s_reg;
		s_next.nap_s1 = l_reg.nap_lvl;
		s_next.nap_s2 = s_reg.nap_s1;
		s_next.pwr_s1 = l_reg.pwr_lvl;
		s_next.pwr_s2 = s_reg.pwr_s1;
		if (!s_reg.nap_s2) begin
			s_next.nap_cnt   = 10'h000;
			s_next.auto_sent = 1'b0;
		end else if (s_reg.nap_cnt != NAP_LIMIT_CYC) begin
			s_next.nap_cnt = s_reg.nap_cnt + 10'h001;
		end
		if (auto_exit && cdc_ready) begin
			s_next.auto_sent = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign auto_exit = s_reg.nap_s2 && !s_reg.auto_sent
		&& (s_reg.nap_cnt == NAP_LIMIT_CYC); // see R01
	assign cdc_valid = cmd_valid || auto_exit;
	assign cdc_op    = auto_exit ? OP_EXIT : cmd_op;
	assign cdc_dev   = cmd_dev;
	assign cmd_ready = cdc_ready && !auto_exit;

	dpc_cdc u_cdc (
		.clk      (clk),
		.srst     (srst),
		.in_valid (cdc_valid),
		.in_op    (cdc_op),
		.in_dev   (cdc_dev),
		.in_ready (cdc_ready),
		.link_clk (chan_clk),
		.link_rst (link_rst),
		.lk       (lk.cdc)
	);

	dpc_sck_gen u_sck (
		.clk  (clk),
		.srst (srst),
		.fast (s_reg.pwr_s2),
		.sck  (sck)
	);

	// Counters hold the distance to the strobe now on the wires, hence the minus one
	assign rd_ok = ((l_reg.since_cc >= CC_TO_RD - 8'h01) || (lk.dev != l_reg.cc_last)) // see R04
		&& (l_reg.since_temp_calibrate_cmd >= Q_END - 8'h01); // see R10

	// Channel side scheduler
	always_comb begin
		l_next             = l_reg;
		l_next.row_frame   = 1'b0;
		l_next.col_frame   = 1'b0;
		l_next.read_stb    = 1'b0;
		l_next.cc_stb      = 1'b0;
		l_next.temp_calibrate_cmd_stb    = 1'b0;
		l_next.sleep_entry = 1'b0;
		l_next.exit_stb    = 1'b0;
		l_next.ref_valid   = 1'b0;
		l_next.row_bits    = 3'h0;
		l_next.col_bits    = 5'h00;
		l_next.sr_s1       = self_refresh_en;
		l_next.sr_s2       = l_reg.sr_s1;
		lk.take            = 1'b0;
		if (l_reg.since_rd != 8'hFF) begin
			l_next.since_rd = l_reg.since_rd + 8'h01;
		end
		if (l_reg.since_cc != 8'hFF) begin
			l_next.since_cc = l_reg.since_cc + 8'h01;
		end
		if (l_reg.since_temp_calibrate_cmd != 8'hFF) begin
			l_next.since_temp_calibrate_cmd = l_reg.since_temp_calibrate_cmd + 8'h01;
		end
		case (l_reg.st)
			L_IDLE: begin
				if (lk.valid) begin
					case (lk.op)
						OP_READ: begin
							if (rd_ok) begin
								lk.take         = 1'b1;
								l_next.read_stb = 1'b1;
								l_next.dev_o    = lk.dev;
								l_next.col_bits = COL_RD;
								l_next.since_rd = 8'h00;
							end
						end
						OP_CCAL: begin
							if (l_reg.since_rd >= RD_TO_CC - 8'h01) begin // see R03
								lk.take         = 1'b1;
								l_next.cc_stb   = 1'b1;
								l_next.dev_o    = l_reg.cc_dev; // see R14
								l_next.cc_last  = l_reg.cc_dev;
								l_next.cc_dev   = (l_reg.cc_dev == DEV_LAST) ? '0
									: l_reg.cc_dev + DEV_W'(1); // see R14
								l_next.col_bits = COL_CC;
								l_next.since_cc = 8'h00;
							end
						end
						OP_TEMP_CALIBRATE_CMD: begin
							if (l_reg.since_temp_calibrate_cmd >= TEMP_CALIBRATE_CMD_GAP - 8'h01) begin // see R08
								lk.take           = 1'b1;
								l_next.temp_calibrate_cmd_stb   = 1'b1;
								l_next.row_bits   = ROW_TEMP_CALIBRATE_CMD;
								l_next.since_temp_calibrate_cmd = 8'h00; // see R09
							end
						end
						OP_ATTENTION_STATE: begin
							lk.take          = 1'b1;
							l_next.row_frame = 1'b1;
							l_next.dev_o     = lk.dev;
							l_next.row_bits  = ROW_ACT;
							l_next.st        = L_FRAME;
							l_next.cnt       = 8'h01;
						end
						OP_NAP, OP_PDN: begin
							lk.take    = 1'b1;
							l_next.deep_sleep_state = lk.op == OP_PDN;
							l_next.st  = L_ENTER;
							l_next.cnt = 8'h01;
						end
						default: begin
							lk.take = 1'b1;
						end
					endcase
				end
			end
			L_FRAME: begin
				l_next.cnt = l_reg.cnt + 8'h01;
				if (l_reg.cnt == FRM_CYC) begin // see R02
					l_next.col_frame = 1'b1;
					l_next.col_bits  = COL_ACT;
					l_next.st        = L_IDLE;
				end
			end
			L_ENTER: begin
				l_next.cnt = l_reg.cnt + 8'h01;
				if (l_reg.cnt == ENTRY_QUIET) begin // see R07
					l_next.sleep_entry = 1'b1;
					l_next.st          = L_SLEEP;
					l_next.cnt         = 8'h00;
				end
			end
			L_SLEEP: begin
				if (l_reg.cnt != 8'hFF) begin
					l_next.cnt = l_reg.cnt + 8'h01;
				end
				l_next.cfm_en = !(l_reg.cnt >= CLK_POST - 8'h01); // see R06
				// Any pending command wakes the device; only an exit is consumed here
				if (lk.valid) begin
					lk.take       = lk.op == OP_EXIT;
					l_next.cfm_en = 1'b1;
					l_next.st     = L_EXIT_W;
					l_next.cnt    = 8'h00;
				end
			end
			L_EXIT_W: begin
				l_next.cnt = l_reg.cnt + 8'h01;
				if (l_reg.cnt == CLK_PRE - 8'h01) begin // see R05
					l_next.st  = L_EXIT_Q;
					l_next.cnt = 8'h00;
				end
			end
			L_EXIT_Q: begin
				l_next.cnt      = l_reg.cnt + 8'h01;
				l_next.exit_stb = l_reg.cnt == EXIT_SETUP - 8'h01; // see R12
				if (l_reg.cnt == EXIT_SETUP + EXIT_HOLD) begin // see R12
					l_next.st  = l_reg.sr_s2 ? L_REFRESH : L_IDLE; // see R13
					l_next.cnt = 8'h00;
				end
			end
			L_REFRESH: begin
				l_next.ref_valid = 1'b1; // see R13
				l_next.ref_bank  = l_reg.cnt[BANK_W-1:0];
				l_next.row_bits  = ROW_REF;
				l_next.cnt       = l_reg.cnt + 8'h01;
				if (l_reg.cnt == NBANK - 8'h01) begin
					l_next.st = L_IDLE;
				end
			end
			default: begin
				l_next.st = L_IDLE;
			end
		endcase
		l_next.nap_lvl = (l_next.st == L_SLEEP) && !l_next.deep_sleep_state;
		l_next.pwr_lvl = l_next.st inside {L_ENTER, L_SLEEP, L_EXIT_W, L_EXIT_Q};
	end

	always_ff @(posedge chan_clk) begin
		if (link_rst) begin
			l_reg            <= '0;
			l_reg.since_rd   <= 8'hFF;
			l_reg.since_cc   <= 8'hFF;
			l_reg.since_temp_calibrate_cmd <= 8'hFF;
			l_reg.cfm_en     <= 1'b1;
		end else begin
			l_reg <= l_next;
		end
	end

	assign row_bits    = l_reg.row_bits;
	assign col_bits    = l_reg.col_bits;
	assign row_frame   = l_reg.row_frame;
	assign col_frame   = l_reg.col_frame;
	assign read_strobe = l_reg.read_stb;
	assign cc_strobe   = l_reg.cc_stb;
	assign temp_calibrate_cmd_strobe = l_reg.temp_calibrate_cmd_stb;
	assign dev_o       = l_reg.dev_o;
	assign sleep_entry = l_reg.sleep_entry;
	assign cfm_en      = l_reg.cfm_en;
	assign exit_strobe = l_reg.exit_stb;
	assign ref_valid   = l_reg.ref_valid;
	assign ref_bank    = l_reg.ref_bank;
	assign quiet       = (row_bits == 3'h0) && (col_bits == 5'h00);

	a_nap_exit_due: assert property (@(posedge clk) disable iff (srst) // see R01
		(s_reg.nap_s2 && !s_reg.auto_sent && s_reg.nap_cnt == NAP_LIMIT_CYC && cdc_ready)
		|-> cdc_valid && cdc_op == OP_EXIT)
		else $error("light sleep limit reached without an exit");

	a_frame_delay: assert property (@(posedge chan_clk) disable iff (link_rst) // see R02
		row_frame |-> ##FRM_DLY col_frame)
		else $error("column framing not at the set delay after row framing");

	a_read_to_cc: assert property (@(posedge chan_clk) disable iff (link_rst) // see R03
		read_strobe |=> (!cc_strobe)[*8] ##1 (!cc_strobe)[*3])
		else $error("calibration packet too close after read data");

	a_cc_to_read: assert property (@(posedge chan_clk) disable iff (link_rst) // see R04
		cc_strobe |=> (!(read_strobe && dev_o == l_reg.cc_last))[*7])
		else $error("read of calibrated device too soon");

	a_exit_clk_run: assert property (@(posedge chan_clk) disable iff (link_rst) // see R05
		exit_strobe |-> $past(cfm_en, 1) && $past(cfm_en, 2) && $past(cfm_en, 3))
		else $error("channel clock not stable before exit");

	a_entry_clk_hold: assert property (@(posedge chan_clk) disable iff (link_rst) // see R06
		(l_reg.st == L_SLEEP && l_reg.cnt < CLK_POST) |-> cfm_en)
		else $error("channel clock stopped too soon after entry");

	a_entry_quiet: assert property (@(posedge chan_clk) disable iff (link_rst) // see R07
		sleep_entry |-> $past(quiet, 1) && $past(quiet, 2) && $past(quiet, 3) && $past(quiet, 4))
		else $error("request wires not quiet during sleep entry");

	a_temp_calibrate_cmd_spacing: assert property (@(posedge chan_clk) disable iff (link_rst) // see R08
		temp_calibrate_cmd_strobe |-> $past(l_reg.since_temp_calibrate_cmd) >= TEMP_CALIBRATE_CMD_GAP - 8'h01)
		else $error("temperature calibrate commands too close");

	a_temp_calibrate_cmd_no_read: assert property (@(posedge chan_clk) disable iff (link_rst) // see R10
		temp_calibrate_cmd_strobe |-> ##2 (!read_strobe)[*8])
		else $error("read data inside temperature quiet window");

	a_exit_quiet: assert property (@(posedge chan_clk) disable iff (link_rst) // see R12
		exit_strobe |-> $past(quiet) ##0 quiet[*6])
		else $error("row or column bits active around exit");

	a_cc_dev_step: assert property (@(posedge chan_clk) disable iff (link_rst) // see R14
		cc_strobe |-> l_reg.cc_dev != $past(l_reg.cc_dev) || NDEV == 1)
		else $error("device field not stepped after calibration");

endmodule : dpc_host

/* File: dpc_dev_model.sv */
`timescale 1ns/1ns
module dpc_dev_model (
	input  wire logic                      chan_clk,
	input  wire logic [2:0]                row_bits,
	input  wire logic [4:0]                col_bits,
	input  wire logic                      row_frame,
	input  wire logic                      col_frame,
	input  wire logic                      read_strobe,
	input  wire logic                      cc_strobe,
	input  wire logic                      temp_calibrate_cmd_strobe,
	input  wire logic [dpc_pkg::DEV_W-1:0] dev_o,
	input  wire logic                      sleep_entry,
	input  wire logic                      cfm_en,
	input  wire logic                      exit_strobe,
	input  wire logic                      sck,
	output int                             viol
);
	import dpc_pkg::*;
	int               cyc   = 0;
	int               t_row = -999;
	int               t_rd  = -999;
	int               t_cc  = -999;
	int               t_tc  = -999;
	int               t_ent = -999;
	int               t_ex  = -999;
	int               qrun  = 0;
	int               crun  = 0;
	logic [DEV_W-1:0] cc_dev = '0;
	logic             asleep = 1'b0;
	realtime          t_sl  = 0;
	realtime          t_sck = 0;
	initial viol = 0;
	// Device view of the channel: every strobe or cycle that breaches a timing window adds one
	always @(posedge chan_clk) begin
		cyc++;
		if (col_frame === 1'b1 && (cyc - t_row < 7 || cyc - t_row > 10)) viol++;
		if (row_frame === 1'b1) t_row = cyc;
		if (cc_strobe === 1'b1) begin
			if (cyc - t_rd < 12) viol++;
			t_cc = cyc;
			cc_dev = dev_o;
		end
		if (read_strobe === 1'b1) begin
			if (dev_o === cc_dev && cyc - t_cc < 8) viol++;
			// Quiet window opens 2 cycles after the command and lasts 140
			if (cyc - t_tc >= 2 && cyc - t_tc < 142) viol++;
			t_rd = cyc;
		end
		if (temp_calibrate_cmd_strobe === 1'b1) begin
			if (cyc - t_tc < 150) viol++;
			t_tc = cyc;
		end
		if (sleep_entry === 1'b1) begin
			if (qrun < 4) viol++;
			t_ent = cyc;
			t_sl = $realtime;
			asleep = 1'b1;
		end
		if (cfm_en !== 1'b1 && cyc - t_ent < 100) viol++;
		if (exit_strobe === 1'b1) begin
			if (crun < 2) viol++;
			if (asleep && $realtime - t_sl > 10000) viol++;
			asleep = 1'b0;
			t_ex = cyc;
		end
		if ((row_bits | col_bits) !== 5'h00 && cyc - t_ex >= 1 && cyc - t_ex <= 5) viol++;
		qrun = ((row_bits | col_bits) === 5'h00) ? qrun + 1 : 0;
		crun = (cfm_en === 1'b1) ? crun + 1 : 0;
	end
	always @(posedge sck) begin
		if ($realtime - t_sck < 10) viol++;
		t_sck = $realtime;
	end
endmodule : dpc_dev_model

/* File: testbench.sv */
`timescale 1ns/1ns
module testbench;
	import dpc_pkg::*;
	localparam int NDEV = 4;
	logic                clk = 0, srst = 1, chan_clk = 0, cmd_valid = 0, self_refresh_en = 0;
	dpc_op_e             cmd_op = OP_READ;
	logic [DEV_W-1:0]    cmd_dev = '0, dev_o;
	logic                cmd_ready, row_frame, col_frame, read_strobe, cc_strobe, temp_calibrate_cmd_strobe;
	logic                sleep_entry, cfm_en, exit_strobe, ref_valid, sck;
	logic [2:0]          row_bits;
	logic [4:0]          col_bits;
	logic [BANK_W-1:0]   ref_bank;
	int                  fails = 0, tests_run = 0, viol, cc_n = 0;
	logic [8:0]          exp_q[$];
	logic                asleep = 0;
	realtime             sck_t = 0, sck_per = 0;
	initial forever #5 clk = ~clk;
	// Link clock phase is deliberately unrelated to clk
	initial begin
		#7;
		forever #32 chan_clk = ~chan_clk;
	end
	dpc_host #(.FRM_DLY(9), .NDEV(NDEV)) i_dut (.*);
	dpc_dev_model i_dev (.*);
	function automatic logic [8:0] ev(int k, logic [DEV_W-1:0] d);
		return {4'(k), d};
	endfunction : ev
	task automatic tally_and_finish;
		$display("tests_run=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	task automatic bad(string m);
		fails++;
		$display("Error %0t %s", $time, m);
	endtask : bad
	task automatic chk_ev(logic [8:0] got, logic [8:0] exp);
		tests_run++;
		if (got !== exp) bad("channel event differs from model");
	endtask : chk_ev
	task automatic chk_val(logic [31:0] got, logic [31:0] exp);
		tests_run++;
		if (got !== exp) bad("value differs from model");
	endtask : chk_val
	task automatic pop(logic [8:0] g);
		if (exp_q.size() == 0) bad("unexpected channel event");
		else chk_ev(g, exp_q.pop_front());
	endtask : pop
	always @(posedge chan_clk) if (srst === 1'b0) begin
		if (read_strobe === 1'b1) pop(ev(1, dev_o));
		if (cc_strobe === 1'b1) pop(ev(2, dev_o));
		if (temp_calibrate_cmd_strobe === 1'b1) pop(ev(3, 0));
		if (row_frame === 1'b1) pop(ev(4, dev_o));
		if (col_frame === 1'b1) pop(ev(5, dev_o));
		if (sleep_entry === 1'b1) pop(ev(6, 0));
		if (exit_strobe === 1'b1) pop(ev(7, 0));
		if (ref_valid === 1'b1) pop(ev(8, ref_bank));
	end
	always @(posedge sck) begin
		sck_per = $realtime - sck_t;
		sck_t = $realtime;
	end
	task automatic exp_exit;
		exp_q.push_back(ev(7, 0));
		if (self_refresh_en) for (int b = 0; b < 32; b++) exp_q.push_back(ev(8, 5'(b)));
		asleep = 0;
	endtask : exp_exit
	task automatic send(dpc_op_e op, logic [DEV_W-1:0] d);
		int n;
		// One edge between calls, so the request never drops and rises in one step
		@(posedge clk) #1;
		cmd_op = op;
		cmd_dev = d;
		cmd_valid = 1;
		for (n = 0; n < 5000 && cmd_ready !== 1'b1; n++) @(posedge clk) #1;
		if (n == 5000) begin
			bad("command never taken");
			tally_and_finish;
		end
		@(posedge clk) #1;
		cmd_valid = 0;
		if (asleep && op != OP_EXIT) exp_exit;
		case (op)
			OP_READ: exp_q.push_back(ev(1, d));
			OP_CCAL: begin
				exp_q.push_back(ev(2, 5'(cc_n % NDEV)));
				cc_n++;
			end
			OP_TEMP_CALIBRATE_CMD: exp_q.push_back(ev(3, 0));
			OP_ATTENTION_STATE: begin
				exp_q.push_back(ev(4, d));
				exp_q.push_back(ev(5, d));
			end
			OP_NAP, OP_PDN: begin
				exp_q.push_back(ev(6, 0));
				asleep = 1;
			end
			default: if (asleep) exp_exit;
		endcase
	endtask : send
	task automatic wait_idle(string name);
		int n;
		for (n = 0; n < 20000 && exp_q.size() > 0; n++) @(posedge clk);
		if (n == 20000) begin
			bad("channel events missing");
			tally_and_finish;
		end
		repeat (20) @(posedge clk);
		#1;
		$display("test %s done", name);
	endtask : wait_idle
	initial begin
		int i;
		void'($urandom(1731));
		repeat (4) @(posedge chan_clk);
		@(posedge clk) #1;
		srst = 0;
		repeat (4) @(posedge chan_clk);
		@(posedge clk) #1;
		// Calibration packets wedged between reads, same device after
		for (i = 0; i < 6; i++) begin
			send(OP_READ, 5'($urandom));
			send(OP_CCAL, 5'($urandom));
			send(OP_READ, 5'((cc_n - 1) % NDEV));
		end
		wait_idle("reads_cc");
		send(OP_TEMP_CALIBRATE_CMD, 0);
		send(OP_READ, 5'($urandom));
		send(OP_TEMP_CALIBRATE_CMD, 0);
		wait_idle("temp_calibrate_cmd");
		for (i = 0; i < 3; i++) send(OP_ATTENTION_STATE, 5'($urandom));
		wait_idle("attention_state");
		for (i = 0; i < 4; i++) begin
			self_refresh_en = i[0];
			send(i[1] ? OP_PDN : OP_NAP, 0);
			wait_idle("entry");
			// Stay well inside the light sleep limit so no automatic exit interferes
			repeat (150 + $urandom % 600) @(posedge clk);
			#1;
			send(OP_EXIT, 0);
			wait_idle("exit");
		end
		// A command during sleep wakes the device first
		self_refresh_en = 1;
		send(OP_NAP, 0);
		wait_idle("entry");
		send(OP_READ, 5'($urandom));
		wait_idle("wake_read");
		// Left asleep, the controller must leave by itself
		self_refresh_en = 0;
		send(OP_NAP, 0);
		wait_idle("entry");
		exp_exit;
		wait_idle("auto_exit");
		send(OP_EXIT, 0);
		send(OP_READ, 5'($urandom));
		wait_idle("exit_awake");
		repeat (300) @(posedge clk);
		chk_val(32'(sck_per >= 1000), 1);
		chk_val(viol, 0);
		tally_and_finish;
	end
endmodule : testbench
